/* core/ssm_map.vh */
// Purpose: Register map and timing constants for sync signal measurement
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: Included by the measurement core only
`ifndef SSM_MAP_VH
`define SSM_MAP_VH
// Register offsets
`define SSM_ADDR_VPER_HI 16'h000d
`define SSM_ADDR_VPER_LO 16'h000e
`define SSM_ADDR_LINE_HI 16'h000f
`define SSM_ADDR_LINE_LO 16'h0010
`define SSM_ADDR_INT_CTL 16'h0011
`define SSM_ADDR_HPER 16'h001e
`define SSM_ADDR_SRC_SEL 16'h0012
// Field positions
`define SSM_BIT_VIE 7
`define SSM_BIT_OVF 7
`define SSM_BIT_SRC 0
`define SSM_BIT_VERTICAL_DETECT_FLAG 1
`define SSM_BIT_HORIZONTAL_DETECT_FLAG 2
// Reset values
`define SSM_RST_BYTE 8'h00
// Timing counts in core cycles; SSM_LINE_MAX in lines
`define SSM_VPRESCALE 4'hf
`define SSM_HWIDTH_MAX 16'd16
`define SSM_VWIDTH_MAX 16'd960
`define SSM_VPER_MAX 17'd131000
`define SSM_HPER_MIN 9'd18
`define SSM_HPER_MAX 9'd256
`define SSM_LINE_MAX 13'd4096
// Duty balance limits for polarity; small so a polarity swap settles in a few lines
`define SSM_POL_CEIL 16'h0400
`define SSM_POL_FLOOR 16'hfc00
`endif

/* core/ssm_sync_measure.v */
// Purpose: Measure vertical period, lines per frame and horizontal period
// Assumes: Sync pins asynchronous; one 10 MHz clock; synchronous reset
// Notes: Vertical interrupt request cleared by vector fetch strobe
`include "ssm_map.vh"
`timescale 1ns/1ns
`default_nettype none
module ssm_sync_measure (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Sync pins
    input wire hsyncPin,
    input wire vsyncPin,
    // Register port
    input wire [15:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // Interrupt handshake
    input wire vectorFetch,
    input wire cpuIntMask,
    output reg vsyncIrq,
    // Sync outputs
    output reg hsyncOut,
    output reg vsyncOut
);

////////////////////////////////////////////////////////////////////////
reg [1:0] hSync_q;
reg [1:0] vSync_q;
reg hLvl_q;
reg vLvl_q;
reg hPolAcc_q;
reg vPolAcc_q;
reg hPol_q;
reg vPol_q;
reg [15:0] hHigh_q;
reg [15:0] vHigh_q;
reg [15:0] hLowW_q;
reg [15:0] vLowW_q;
reg [15:0] hBal_q;
reg [15:0] vBal_q;
reg compDet_q;
wire hRaw = hSync_q[1];
wire vRaw = vSync_q[1];

// Two flops before use
always @(posedge core_clk)
begin
    if (srst)
    begin
        hSync_q <= 2'h0;
        vSync_q <= 2'h0;
    end
    else
    begin
        hSync_q <= {hSync_q[0], hsyncPin};
        vSync_q <= {vSync_q[0], vsyncPin};
    end
end

// Polarity from duty
// Pulse is the rarer state; a duty balance, not one width, so serrations cannot flip it
always @(posedge core_clk)
begin
    if (srst)
    begin
        hHigh_q <= 16'h0000;
        vHigh_q <= 16'h0000;
        hPol_q <= 1'b0;
        vPol_q <= 1'b0;
        hBal_q <= 16'h0000;
        vBal_q <= 16'h0000;
    end
    else
    begin
        hHigh_q <= hRaw ? ((hHigh_q == 16'hffff) ? hHigh_q : hHigh_q + 16'h0001) : 16'h0000;
        vHigh_q <= vRaw ? ((vHigh_q == 16'hffff) ? vHigh_q : vHigh_q + 16'h0001) : 16'h0000;
        if (hRaw && hBal_q != `SSM_POL_CEIL)
            hBal_q <= hBal_q + 16'h0001;
        else if (!hRaw && hBal_q != `SSM_POL_FLOOR)
            hBal_q <= hBal_q - 16'h0001;
        if (vRaw && vBal_q != `SSM_POL_CEIL)
            vBal_q <= vBal_q + 16'h0001;
        else if (!vRaw && vBal_q != `SSM_POL_FLOOR)
            vBal_q <= vBal_q - 16'h0001;
        // Mostly high means low-going pulses: invert
        hPol_q <= !hBal_q[15] && hBal_q != 16'h0000;
        vPol_q <= !vBal_q[15] && vBal_q != 16'h0000;
    end
end

always @(posedge core_clk)
begin
    if (srst)
    begin
        hLowW_q <= 16'h0000;
        vLowW_q <= 16'h0000;
        hLvl_q <= 1'b0;
        vLvl_q <= 1'b0;
        hPolAcc_q <= 1'b0;
        vPolAcc_q <= 1'b0;
    end
    else
    begin
        hLowW_q <= !hRaw ? ((hLowW_q == 16'hffff) ? hLowW_q : hLowW_q + 16'h0001) : 16'h0000;
        vLowW_q <= !vRaw ? ((vLowW_q == 16'hffff) ? vLowW_q : vLowW_q + 16'h0001) : 16'h0000;
        // Active-high pulse after correction
        hLvl_q <= hRaw ^ hPol_q;
        vLvl_q <= vRaw ^ vPol_q;
        hPolAcc_q <= hLvl_q;
        vPolAcc_q <= vLvl_q;
    end
end

////////////////////////////////////////////////////////////////////////
// Source select and composite separation
reg srcSel_q;
reg [15:0] pulseW_q;
reg compV_q;
wire hRise = hLvl_q & ~hPolAcc_q;
wire hFall = ~hLvl_q & hPolAcc_q;
wire vRiseSep = vLvl_q & ~vPolAcc_q;
wire vFallSep = ~vLvl_q & vPolAcc_q;

// Composite separation
// Wide pulse on the horizontal input is a vertical pulse
always @(posedge core_clk)
begin
    if (srst)
    begin
        pulseW_q <= 16'h0000;
        compV_q <= 1'b0;
    end
    else
    begin
        // Run length of the current corrected level
        pulseW_q <= (hRise || hFall) ? 16'h0000 : ((pulseW_q == 16'hffff) ? pulseW_q : pulseW_q + 16'h0001);
        if (hLvl_q && pulseW_q == `SSM_HWIDTH_MAX)
            compV_q <= 1'b1;
        // Serration gaps are short; only a wide gap ends the vertical pulse
        else if (!hLvl_q && pulseW_q == `SSM_HWIDTH_MAX)
            compV_q <= 1'b0;
    end
end

reg compVd_q;
always @(posedge core_clk)
begin
    if (srst)
        compVd_q <= 1'b0;
    else
        compVd_q <= compV_q;
end
wire compVLead = compV_q & ~compVd_q;
wire compVTrail = ~compV_q & compVd_q;
wire useSep = srcSel_q & ~compDet_q;
wire vLead = useSep ? vRiseSep : compVLead;
wire vTrail = useSep ? vFallSep : compVTrail;
wire vPulse = useSep ? vLvl_q : compV_q;

////////////////////////////////////////////////////////////////////////
// Activity detection
reg [16:0] vGap_q;
reg [8:0] hGap_q;
reg vertical_detect_flag_q;
reg horizontal_detect_flag_q;
reg [3:0] preDiv_q;
reg [12:0] vCnt_q;
reg [12:0] vPer_q;
reg [12:0] lineCnt_q;
reg [11:0] linePer_q;
reg lineOvf_q;
reg [7:0] hCnt_q;
reg [7:0] hPer_q;
reg hWrap_q;
reg vieEn_q;

always @(posedge core_clk)
begin
    if (srst)
    begin
        vGap_q <= 17'h00000;
        hGap_q <= 9'h000;
        vertical_detect_flag_q <= 1'b0;
        horizontal_detect_flag_q <= 1'b0;
        compDet_q <= 1'b0;
    end
    else
    begin
        vGap_q <= vLead ? 17'h00000 : ((vGap_q == `SSM_VPER_MAX) ? vGap_q : vGap_q + 17'h00001);
        hGap_q <= hRise ? 9'h000 : ((hGap_q == `SSM_HPER_MAX) ? hGap_q : hGap_q + 9'h001);
        if (vGap_q == `SSM_VPER_MAX || vHigh_q > `SSM_VWIDTH_MAX && vLowW_q > `SSM_VWIDTH_MAX)
            vertical_detect_flag_q <= 1'b0;
        else if (vLead)
            vertical_detect_flag_q <= 1'b1;
        if (hWrap_q || hGap_q == `SSM_HPER_MAX)
            horizontal_detect_flag_q <= 1'b0;
        else if (hRise && hGap_q > `SSM_HPER_MIN)
            horizontal_detect_flag_q <= 1'b1;
        // A separate vertical pulse in separate mode ends composite precedence
        if (vGap_q == `SSM_VPER_MAX || (srcSel_q && vRiseSep))
            compDet_q <= 1'b0;
        else if (compVLead && horizontal_detect_flag_q)
            compDet_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// Counters
always @(posedge core_clk)
begin
    if (srst)
    begin
        preDiv_q <= 4'h0;
        vCnt_q <= 13'h0000;
        vPer_q <= 13'h0000;
        lineCnt_q <= 13'h0000;
        linePer_q <= 12'h000;
        lineOvf_q <= 1'b0;
        hCnt_q <= 8'h00;
        hPer_q <= 8'h00;
        hWrap_q <= 1'b0;
    end
    else
    begin
        preDiv_q <= preDiv_q + 4'h1;
        if (vLead)
        begin
            vPer_q <= vCnt_q;
            vCnt_q <= 13'h0000;
        end
        else if (preDiv_q == `SSM_VPRESCALE)
            vCnt_q <= vCnt_q + 13'h0001;
        if (vLead)
        begin
            // Composite vertical rise is not a line
            linePer_q <= (useSep || lineCnt_q == 13'h0000) ? lineCnt_q[11:0] : lineCnt_q[11:0] - 12'h001;
            lineOvf_q <= lineCnt_q > `SSM_LINE_MAX;
            // Coinciding line edge opens the new frame
            lineCnt_q <= hRise ? 13'h0001 : 13'h0000;
        end
        else if (hRise)
            lineCnt_q <= (lineCnt_q == 13'h1fff) ? lineCnt_q : lineCnt_q + 13'h0001;
        if (!vertical_detect_flag_q)
            lineOvf_q <= 1'b1;
        // Sampled pin costs up to two counts
        // First line after vertical not guarded
        if (hRise)
        begin
            hPer_q <= hCnt_q;
            hCnt_q <= 8'h00;
            hWrap_q <= 1'b0;
        end
        else
        begin
            hCnt_q <= hCnt_q + 8'h01;
            if (hCnt_q == 8'hff)
                hWrap_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Interrupt and sync outputs
reg [8:0] intH_q;
reg [16:0] intV_q;
always @(posedge core_clk)
begin
    if (srst)
    begin
        vsyncIrq <= 1'b0;
        intH_q <= 9'h000;
        intV_q <= 17'h00000;
        hsyncOut <= 1'b0;
        vsyncOut <= 1'b0;
    end
    else
    begin
        // Request per leading edge
        // A new edge in the fetch cycle keeps the request
        if (vLead && vieEn_q && !cpuIntMask)
            vsyncIrq <= 1'b1;
        else if (vectorFetch)
            vsyncIrq <= 1'b0;
        intH_q <= (intH_q == `SSM_HPER_MAX - 9'd1) ? 9'h000 : intH_q + 9'h001;
        intV_q <= (intV_q == `SSM_VPER_MAX - 17'd1) ? 17'h00000 : intV_q + 17'h00001;
        if (horizontal_detect_flag_q && vertical_detect_flag_q)
        begin
            hsyncOut <= hLvl_q & ~vPulse;
            vsyncOut <= vPulse;
        end
        else
        begin
            hsyncOut <= intH_q < `SSM_HWIDTH_MAX;
            vsyncOut <= intV_q < {1'b0, `SSM_VWIDTH_MAX};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register port
// Vertical validity is the detect flag
// Line validity from vertical detect flag and overflow
wire [7:0] srcStat = {5'h00, horizontal_detect_flag_q, vertical_detect_flag_q, srcSel_q};
always @(posedge core_clk)
begin
    if (srst)
    begin
        vieEn_q <= 1'b0;
        srcSel_q <= 1'b0;
        regRdata <= `SSM_RST_BYTE;
    end
    else
    begin
        if (regWr && regAddr == `SSM_ADDR_INT_CTL)
            vieEn_q <= regWdata[`SSM_BIT_VIE];
        if (regWr && regAddr == `SSM_ADDR_SRC_SEL)
            srcSel_q <= regWdata[`SSM_BIT_SRC];
        regRdata <= `SSM_RST_BYTE;
        if (regRd)
        begin
            case (regAddr)
                `SSM_ADDR_VPER_HI: regRdata <= {3'h0, vPer_q[12:8]};
                `SSM_ADDR_VPER_LO: regRdata <= vPer_q[7:0];
                `SSM_ADDR_LINE_HI: regRdata <= {lineOvf_q, 3'h0, linePer_q[11:8]};
                `SSM_ADDR_LINE_LO: regRdata <= linePer_q[7:0];
                `SSM_ADDR_INT_CTL: regRdata <= {vieEn_q, 7'h00};
                `SSM_ADDR_HPER: regRdata <= hPer_q;
                `SSM_ADDR_SRC_SEL: regRdata <= srcStat;
                default: regRdata <= `SSM_RST_BYTE;
            endcase
        end
    end
end

endmodule // ssm_sync_measure
`default_nettype wire

/* tb/ssm_video_source.sv */
// Purpose: Video source model driving the sync pins
// Assumes: Line and frame lengths set by the bench
// Notes: Composite vertical lines use wide pulses
`timescale 1ns/1ns
`default_nettype none
module ssm_video_source (
    // Control
    input wire logic core_clk,
    input wire logic runEn,
    input wire logic composite,
    input wire logic invertPol,
    input wire logic [8:0] hPeriod,
    input wire logic [7:0] vLines,
    // Sync pins
    output logic hsyncPin = 1'b0,
    output logic vsyncPin = 1'b0
);
    logic [8:0] hCnt_q = 9'h000;
    logic [7:0] line_q = 8'h00;
    logic lineEnd, vAct, hAct;
    assign lineEnd = hCnt_q + 9'h001 >= hPeriod;
    assign vAct = runEn && line_q < 8'h03;
    assign hAct = runEn && (vAct && composite ? hCnt_q < hPeriod - 9'h008 : hCnt_q < 9'h008);
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        hCnt_q <= lineEnd ? 9'h000 : hCnt_q + 9'h001;
        if (lineEnd)
            line_q <= line_q + 8'h01 >= vLines ? 8'h00 : line_q + 8'h01;
        hsyncPin <= hAct ^ invertPol;
        vsyncPin <= (vAct && !composite) ^ invertPol;
    end
endmodule // ssm_video_source
`default_nettype wire

/* tb/ssm_sync_measure_props.sv */
// Purpose: Port checks for sync measurement
// Assumes: One clock, synchronous reset
// Notes: Enable bit tracked from observed writes
`timescale 1ns/1ns
`default_nettype none
module ssm_sync_measure_props (
    // Clock
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // Interrupt
    input wire logic vectorFetch,
    input wire logic cpuIntMask,
    input wire logic vsyncIrq
);
    logic intEn_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    always @(posedge core_clk)
    begin
        if (srst)
            intEn_q <= 1'b0;
        else if (regWr && regAddr == 16'h0011)
            intEn_q <= regWdata[7];
    end
    sequence rdAt(logic [15:0] a);
        regRd && regAddr == a;
    endsequence
    ////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero");
    a_ctl_readback: assert property (rdAt(16'h0011) |=> regRdata == {$past(intEn_q), 7'h00})
        else $error("control readback wrong");
    a_unmapped_zero: assert property (rdAt(16'h0020) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_vper_hi_pad: assert property (rdAt(16'h000d) |=> regRdata[7:5] == 3'h0)
        else $error("vertical high pad bits set");
    a_line_hi_pad: assert property (rdAt(16'h000f) |=> regRdata[6:4] == 3'h0)
        else $error("line high pad bits set");
    a_irq_hold: assert property (vsyncIrq && !vectorFetch |=> vsyncIrq)
        else $error("request dropped without fetch");
    a_irq_enable: assert property ($rose(vsyncIrq) |-> $past(intEn_q))
        else $error("request while disabled");
    a_irq_mask: assert property ($rose(vsyncIrq) |-> !$past(cpuIntMask))
        else $error("request while masked");
endmodule // ssm_sync_measure_props
bind ssm_sync_measure ssm_sync_measure_props ssm_sync_measure_props_inst (.core_clk(core_clk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .vectorFetch(vectorFetch), .cpuIntMask(cpuIntMask), .vsyncIrq(vsyncIrq));
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Register-level test of sync measurement
// Assumes: Composite then separate source
// Notes: Counts allow the asynchronous errors
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk, srst, regWr, regRd, vectorFetch, cpuIntMask, runEn, composite, invertPol;
    logic hsyncPin, vsyncPin, vsyncIrq, hOut, vOut, hOutD;
    int hOutRises = 0;
    logic [15:0] regAddr, w;
    logic [7:0] regWdata, regRdata, rdv, vLines;
    logic [8:0] hPeriod;
    logic [15:0] addrs [6] = '{16'h000d, 16'h000e, 16'h0010, 16'h0011, 16'h001e, 16'h0020};
    int err_total = 0, samples_checked = 0, cycles = 0;
    ssm_sync_measure ssm_sync_measure_inst (.core_clk(core_clk), .srst(srst), .hsyncPin(hsyncPin),
        .vsyncPin(vsyncPin), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .vectorFetch(vectorFetch), .cpuIntMask(cpuIntMask), .vsyncIrq(vsyncIrq),
        .hsyncOut(hOut), .vsyncOut(vOut));
    ssm_video_source ssm_video_source_inst (.core_clk(core_clk), .runEn(runEn), .composite(composite),
        .invertPol(invertPol), .hPeriod(hPeriod), .vLines(vLines), .hsyncPin(hsyncPin), .vsyncPin(vsyncPin));
    ////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        hOutD <= hOut;
        if (hOut && !hOutD)
            hOutRises++;
        if (cycles == 95000)
        begin
            err_total++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input int tol);
        samples_checked++;
        if (^seen === 1'bx || seen > exp + tol || seen + tol < exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    task automatic rd2(input logic [15:0] a);
        rd(a);
        w[15:8] = rdv;
        rd(a + 16'h0001);
        w[7:0] = rdv;
    endtask
    task automatic fetch;
        @(posedge core_clk);
        vectorFetch <= 1'b1;
        @(posedge core_clk);
        vectorFetch <= 1'b0;
        #1 chk(vsyncIrq, 0, 0);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        {srst, regWr, regRd, vectorFetch, cpuIntMask, runEn, composite, invertPol} = 8'h80;
        regAddr = 16'h0000;
        regWdata = 8'h00;
        hPeriod = 9'd100;
        vLines = 8'd80;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        foreach (addrs[i])
        begin
            rd(addrs[i]);
            chk(rdv, 0, 0);
        end
        wr(16'h000e, 8'hff);
        wr(16'h0011, 8'hff);
        rd(16'h000e);
        chk(rdv, 0, 0);
        rd(16'h0011);
        chk(rdv, 16'h0080, 0);
        runEn <= 1'b1;
        composite <= 1'b1;
        repeat (20000) @(posedge core_clk);
        rd(16'h0012);
        chk(rdv & 8'h06, 16'h0006, 0);
        rd2(16'h000f);
        chk(w, 16'd79, 1);
        wr(16'h0012, 8'h01);
        rd(16'h0012);
        chk(rdv & 8'h07, 16'h0007, 0);
        composite <= 1'b0;
        invertPol <= 1'b1;
        repeat (24000) @(posedge core_clk);
        rd(16'h0012);
        chk(rdv & 8'h07, 16'h0007, 0);
        rd2(16'h000d);
        chk(w, 16'd500, 1);
        rd2(16'h000f);
        chk(w, 16'd80, 0);
        rd(16'h001e);
        chk(rdv, 16'd99, 1);
        fetch;
        for (int n = 0; n < 9000 && vsyncIrq !== 1'b1; n++)
            @(posedge core_clk);
        chk(vsyncIrq, 1, 0);
        fetch;
        cpuIntMask <= 1'b1;
        repeat (9000) @(posedge core_clk);
        chk(vsyncIrq, 0, 0);
        cpuIntMask <= 1'b0;
        wr(16'h0011, 8'h00);
        repeat (9000) @(posedge core_clk);
        chk(vsyncIrq, 0, 0);
        hPeriod <= 9'd300;
        repeat (3000) @(posedge core_clk);
        rd(16'h0012);
        chk(rdv & 8'h04, 0, 0);
        hOutRises = 0;
        repeat (2560) @(posedge core_clk);
        chk(hOutRises, 10, 1);
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
